// File: hw/acc_conv_ctrl.sv
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
// Overview of operation
// [R1] Software starts a conversion with one high pulse on the start bit.
// [R2] Start rising edge resets converter; falling edge begins the conversion.
// [R3] Busy flag stays high while conversion runs, clears when finished.
// [R4] Result appears in high and low result bytes once busy falls.
// [R5] Internal source selection disconnects the external channel input.
// [R6] External source routes the channel named by the four-bit selector.
// [R7] Software configures the shared pin for analog input before use.
// [R8] Converter is powered only while the power-on bit is one.
// [R9] Clearing power-on switches off the conversion circuitry entirely; the code still drives o_int_source and o_vref_sel while it is clear.
// [R10] Conversion clock divider follows the three-bit selector in control 1.
// [R11] Reference source follows the two-bit selector in control 1.
// [R12] Result layout across bytes follows the format bit in control 0.
// [R13] Interrupt needs global, converter and multi-function enables all set.
// [R14] Result is a 12-bit unsigned code, step equals reference over 4096.
// [R15] Code transitions sit half LSB low; last one 1.5 LSB below reference.
// [R16] Software configures clock, power, input, reference, format, then starts.
// [R17] Software may poll the busy flag instead of using the interrupt.
// [R18] A clearable converter interrupt request flag is provided.
// [R19] Each conversion is 4 sampling plus 12 converting clock cycles.
// [R20] Divider codes 0 to 7 divide the system clock by 1 to 128.
// [R21] Source codes pick bandgap, amplifiers, negative supply or a pin.
// [R22] Busy sets at start falling edge; request flag rises as busy falls.
// [R23] Sequencer stays idle and ignores start while power-on is clear.
module acc_conv_ctrl
	import acc_pkg::*;
#(
	parameter int DIV_W = 3
) (
	input  wire logic                 i_clk,
	input  wire logic                 i_rst,
	input  wire logic [2:0]           i_addr,
	input  wire logic [7:0]           i_wdata,
	input  wire logic                 i_wr,
	input  wire logic                 i_rd,
	output logic      [7:0]           o_rdata,
	input  wire logic [acc_pkg::ACC_RES_W-1:0] i_sar_code,
	output logic                      o_power_on,
	output logic                      o_conv_reset,
	output logic                      o_sample,
	output logic                      o_convert,
	output logic                      o_ext_connect,
	output logic      [3:0]           o_ext_channel,
	output logic      [2:0]           o_int_source,
	output logic      [1:0]           o_vref_sel,
	output logic                      o_irq
);
	import acc_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [7:0]           ctrl0;
		logic [7:0]           ctrl1;
		logic [3:0]           irq_ctl;
		acc_state_t           state;
		logic [6:0]           pre;
		logic [4:0]           cyc;
		logic                 tick;
		logic [ACC_RES_W-1:0] result;
		logic [7:0]           rdata;
	} acc_regs_t;

	acc_regs_t s_r;
	acc_regs_t s_nxt;

	logic       start_bit;
	logic       power;
	logic       fmt;
	logic [2:0] div_sel;
	logic [2:0] src_sel;
	logic [6:0] div_max;
	logic       ext_src;
	logic       busy;
	logic       done;

	function automatic logic is_external(input logic [2:0] src);
		is_external = !(src == ACC_SRC_BANDGAP || src == ACC_SRC_AMP0 ||
			src == ACC_SRC_AMP1 || src == ACC_SRC_VSS);
	endfunction

	assign start_bit = s_r.ctrl0[ACC_C0_START_BIT];
	assign power     = s_r.ctrl0[ACC_C0_POWER_BIT];
	assign fmt       = s_r.ctrl0[ACC_C0_FMT_BIT];
	assign div_sel   = s_r.ctrl1[ACC_C1_DIV_LSB +: 3];
	assign src_sel   = s_r.ctrl1[ACC_C1_SRC_LSB +: 3];
	assign ext_src   = is_external(src_sel); // R21
	// Divider terminal count: 2**sel - 1
	assign div_max   = 7'((8'h01 << div_sel) - 8'h01); // R20 R10
	assign busy      = (s_r.state == ACC_ST_SAMPLE) ||
		(s_r.state == ACC_ST_CONV); // R3
	assign done = s_r.tick && (s_r.state == ACC_ST_CONV) &&
		(s_r.cyc == 5'(ACC_TOTAL_CYC - 1));

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [7:0] w_ctrl0;
		w_ctrl0 = i_wdata;
		s_nxt = s_r;
		s_nxt.rdata = 8'h00;
		s_nxt.tick = 1'b0;
		if (i_wr) begin
			if (i_addr == ACC_OFS_CTRL0) begin
				// Busy bit is read-only
				w_ctrl0[ACC_C0_BUSY_BIT] = 1'b0;
				s_nxt.ctrl0 = w_ctrl0;
			end else if (i_addr == ACC_OFS_CTRL1) begin
				s_nxt.ctrl1 = i_wdata;
			end else if (i_addr == ACC_OFS_IRQ) begin
				s_nxt.irq_ctl = i_wdata[3:0]; // R18
			end
		end
		// Conversion clock prescaler
		if (s_r.pre >= div_max) begin
			s_nxt.pre = 7'h00;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.pre = s_r.pre + 7'h01;
		end
		case (s_r.state)
			ACC_ST_IDLE: begin
				if (power && s_nxt.ctrl0[ACC_C0_START_BIT] && !start_bit) begin
					s_nxt.state = ACC_ST_RESET; // R2
				end
			end
			ACC_ST_RESET: begin
				if (!s_nxt.ctrl0[ACC_C0_START_BIT]) begin
					s_nxt.state = ACC_ST_SAMPLE; // R22 R2
					s_nxt.cyc = 5'h00;
					s_nxt.pre = 7'h00;
				end
			end
			ACC_ST_SAMPLE: begin
				if (s_r.tick) begin
					s_nxt.cyc = s_r.cyc + 5'h01;
					if (s_r.cyc == 5'(ACC_SAMPLE_CYC - 1)) begin
						s_nxt.state = ACC_ST_CONV; // R19
					end
				end
			end
			ACC_ST_CONV: begin
				if (s_r.tick) begin
					s_nxt.cyc = s_r.cyc + 5'h01;
				end
				if (done) begin
					s_nxt.state = ACC_ST_IDLE;
					s_nxt.result = i_sar_code; // R4 R14 R15
					s_nxt.irq_ctl[ACC_IRQ_FLAG_BIT] = 1'b1; // R22
				end
			end
			default: begin
				s_nxt.state = ACC_ST_IDLE;
			end
		endcase
		// A restart pulse during a conversion resets the converter again
		if (busy && s_nxt.ctrl0[ACC_C0_START_BIT] && !start_bit) begin
			s_nxt.state = ACC_ST_RESET; // R2
		end
		if (!power) begin
			s_nxt.state = ACC_ST_IDLE; // R23 R9
		end
		if (i_rd) begin
			if (i_addr == ACC_OFS_CTRL0) begin
				s_nxt.rdata = s_r.ctrl0;
				s_nxt.rdata[ACC_C0_BUSY_BIT] = busy; // R3
			end else if (i_addr == ACC_OFS_CTRL1) begin
				s_nxt.rdata = s_r.ctrl1;
			end else if (i_addr == ACC_OFS_RES_HIGH) begin
				// R12: format 0 left-aligned, 1 right-aligned
				s_nxt.rdata = fmt ? {4'h0, s_r.result[11:8]} :
					s_r.result[11:4];
			end else if (i_addr == ACC_OFS_RES_LOW) begin
				s_nxt.rdata = fmt ? s_r.result[7:0] :
					{s_r.result[3:0], 4'h0};
			end else if (i_addr == ACC_OFS_IRQ) begin
				s_nxt.rdata = {4'h0, s_r.irq_ctl};
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_r <= '{ctrl0: ACC_CTRL0_RST, ctrl1: ACC_CTRL1_RST,
				irq_ctl: 4'h0, state: ACC_ST_IDLE, pre: 7'h00,
				cyc: 5'h00, tick: 1'b0, result: 12'h000,
				rdata: 8'h00};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_rdata       = s_r.rdata;
	assign o_power_on    = power; // R8 R9
	assign o_conv_reset  = s_r.state == ACC_ST_RESET;
	assign o_sample      = s_r.state == ACC_ST_SAMPLE;
	assign o_convert     = s_r.state == ACC_ST_CONV;
	assign o_ext_connect = power && ext_src &&
		(s_r.ctrl0[ACC_C0_CHAN_LSB +: 4] < ACC_CHAN_FLOAT); // R5 R21
	assign o_ext_channel = s_r.ctrl0[ACC_C0_CHAN_LSB +: 4]; // R6
	assign o_int_source  = ext_src ? 3'h0 : src_sel; // R5
	assign o_vref_sel    = s_r.ctrl1[ACC_C1_VREF_LSB +: 2]; // R11
	assign o_irq = s_r.irq_ctl[ACC_IRQ_FLAG_BIT] &&
		s_r.irq_ctl[ACC_IRQ_CONV_BIT] && s_r.irq_ctl[ACC_IRQ_MF_BIT] &&
		s_r.irq_ctl[ACC_IRQ_GLB_BIT]; // R13

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_start_fall;
		s_r.state == ACC_ST_RESET && !s_nxt.ctrl0[ACC_C0_START_BIT] && power;
	endsequence
	sequence s_start_rise;
		power && s_nxt.ctrl0[ACC_C0_START_BIT] && !start_bit;
	endsequence
	sequence s_rd_at(logic [2:0] ofs);
		i_rd && i_addr == ofs;
	endsequence
	sequence s_wr_at(logic [2:0] ofs);
		i_wr && i_addr == ofs;
	endsequence

	a_busy_on_fall: assert property ( // R22
		@(posedge i_clk) disable iff (i_rst)
		s_start_fall |=> busy)
		else $error("busy not set");
	a_reset_on_rise: assert property ( // R2
		@(posedge i_clk) disable iff (i_rst)
		s_r.state == ACC_ST_IDLE ##0 s_start_rise |=> o_conv_reset)
		else $error("no reset on start");
	a_reset_hold: assert property ( // R2
		@(posedge i_clk) disable iff (i_rst)
		o_conv_reset && power && s_nxt.ctrl0[ACC_C0_START_BIT] |=> o_conv_reset)
		else $error("reset phase dropped");
	a_restart: assert property ( // R2
		@(posedge i_clk) disable iff (i_rst)
		busy ##0 s_start_rise |=> o_conv_reset)
		else $error("restart not taken");
	a_flag_at_end: assert property ( // R22
		@(posedge i_clk) disable iff (i_rst)
		done |=> !busy && s_r.irq_ctl[ACC_IRQ_FLAG_BIT])
		else $error("flag missing at end");
	a_result_load: assert property ( // R4
		@(posedge i_clk) disable iff (i_rst)
		done |=> s_r.result == $past(i_sar_code))
		else $error("result not loaded");
	a_result_hold: assert property ( // R4
		@(posedge i_clk) disable iff (i_rst)
		!done |=> $stable(s_r.result))
		else $error("result changed early");
	a_idle_unpowered: assert property ( // R23
		@(posedge i_clk) disable iff (i_rst)
		!power |=> s_r.state == ACC_ST_IDLE)
		else $error("active while off");
	a_start_ignored: assert property ( // R23
		@(posedge i_clk) disable iff (i_rst)
		s_r.state == ACC_ST_IDLE && !power |=> !o_conv_reset)
		else $error("start taken while off");
	a_sample_len: assert property ( // R19
		@(posedge i_clk) disable iff (i_rst)
		(o_sample && s_r.tick && s_r.cyc == 5'(ACC_SAMPLE_CYC - 1) && !i_wr)
		|=> o_convert)
		else $error("sample length");
	a_sample_count: assert property ( // R19
		@(posedge i_clk) disable iff (i_rst)
		o_sample |-> s_r.cyc < 5'(ACC_SAMPLE_CYC))
		else $error("sample count range");
	a_conv_count: assert property ( // R19
		@(posedge i_clk) disable iff (i_rst)
		o_convert |-> s_r.cyc >= 5'(ACC_SAMPLE_CYC) &&
		s_r.cyc < 5'(ACC_TOTAL_CYC))
		else $error("convert count range");
	a_ext_cut: assert property ( // R5
		@(posedge i_clk) disable iff (i_rst)
		!ext_src |-> !o_ext_connect)
		else $error("ext not cut");
	a_int_src_off: assert property ( // R5
		@(posedge i_clk) disable iff (i_rst)
		ext_src |-> o_int_source == 3'h0)
		else $error("internal source left on");
	a_float_cut: assert property ( // R21
		@(posedge i_clk) disable iff (i_rst)
		s_r.ctrl0[ACC_C0_CHAN_LSB +: 4] >= ACC_CHAN_FLOAT |-> !o_ext_connect)
		else $error("floating channel connected");
	a_off_cut: assert property ( // R9
		@(posedge i_clk) disable iff (i_rst)
		!power |-> !o_ext_connect)
		else $error("switch closed while off");
	a_irq_gate: assert property ( // R13
		@(posedge i_clk) disable iff (i_rst)
		o_irq |-> s_r.irq_ctl == 4'hF)
		else $error("irq gating");
	a_flag_clear: assert property ( // R18
		@(posedge i_clk) disable iff (i_rst)
		s_wr_at(ACC_OFS_IRQ) ##0 (!i_wdata[0] && !done)
		|=> !s_r.irq_ctl[ACC_IRQ_FLAG_BIT])
		else $error("flag not cleared");
	a_flag_set_wins: assert property ( // R18
		@(posedge i_clk) disable iff (i_rst)
		s_wr_at(ACC_OFS_IRQ) ##0 done |=> s_r.irq_ctl[ACC_IRQ_FLAG_BIT])
		else $error("flag set lost to clear");
	a_div_rate: assert property ( // R20
		@(posedge i_clk) disable iff (i_rst)
		(div_sel == 3'h1 && s_r.tick && !i_wr) |=> !s_r.tick)
		else $error("divider rate");
	a_div_one: assert property ( // R20
		@(posedge i_clk) disable iff (i_rst)
		div_sel == 3'h0 |=> s_r.tick)
		else $error("undivided tick missing");
	a_pre_bound: assert property ( // R10
		@(posedge i_clk) disable iff (i_rst)
		!i_wr |=> s_r.pre <= div_max)
		else $error("prescaler overrun");
	a_busy_readonly: assert property ( // R3
		@(posedge i_clk) disable iff (i_rst)
		s_wr_at(ACC_OFS_CTRL0) |=> !s_r.ctrl0[ACC_C0_BUSY_BIT])
		else $error("busy bit written");
	a_busy_readback: assert property ( // R3
		@(posedge i_clk) disable iff (i_rst)
		s_rd_at(ACC_OFS_CTRL0) |=> o_rdata[ACC_C0_BUSY_BIT] == $past(busy))
		else $error("busy readback");
	a_rdata_quiet: assert property ( // R4
		@(posedge i_clk) disable iff (i_rst)
		!i_rd |=> o_rdata == 8'h00)
		else $error("read data not quiet");
	a_high_left: assert property ( // R12
		@(posedge i_clk) disable iff (i_rst)
		s_rd_at(ACC_OFS_RES_HIGH) ##0 !fmt |=> o_rdata == $past(s_r.result[11:4]))
		else $error("left high byte");
	a_low_left: assert property ( // R12
		@(posedge i_clk) disable iff (i_rst)
		s_rd_at(ACC_OFS_RES_LOW) ##0 !fmt
		|=> o_rdata == {$past(s_r.result[3:0]), 4'h0})
		else $error("left low byte");
	a_high_right: assert property ( // R12
		@(posedge i_clk) disable iff (i_rst)
		s_rd_at(ACC_OFS_RES_HIGH) ##0 fmt
		|=> o_rdata == {4'h0, $past(s_r.result[11:8])})
		else $error("right high byte");
	a_low_right: assert property ( // R12
		@(posedge i_clk) disable iff (i_rst)
		s_rd_at(ACC_OFS_RES_LOW) ##0 fmt |=> o_rdata == $past(s_r.result[7:0]))
		else $error("right low byte");
endmodule

// File: hw/acc_pkg.sv
package acc_pkg;
	// ----------------------------------------
	// Register map (byte offsets on the plain port)
	// ----------------------------------------
	localparam logic [2:0] ACC_OFS_CTRL0    = 3'h0;
	localparam logic [2:0] ACC_OFS_CTRL1    = 3'h1;
	localparam logic [2:0] ACC_OFS_RES_HIGH = 3'h2;
	localparam logic [2:0] ACC_OFS_RES_LOW  = 3'h3;
	localparam logic [2:0] ACC_OFS_IRQ      = 3'h4;
	// ----------------------------------------
	// Control register 0 fields
	// ----------------------------------------
	localparam int ACC_C0_CHAN_LSB  = 0;
	localparam int ACC_C0_FMT_BIT   = 4;
	localparam int ACC_C0_POWER_BIT = 5;
	localparam int ACC_C0_BUSY_BIT  = 6;
	localparam int ACC_C0_START_BIT = 7;
	// ----------------------------------------
	// Control register 1 fields
	// ----------------------------------------
	localparam int ACC_C1_DIV_LSB  = 0;
	localparam int ACC_C1_VREF_LSB = 3;
	localparam int ACC_C1_SRC_LSB  = 5;
	// ----------------------------------------
	// Interrupt control register fields
	// ----------------------------------------
	localparam int ACC_IRQ_FLAG_BIT = 0;
	localparam int ACC_IRQ_CONV_BIT = 1;
	localparam int ACC_IRQ_MF_BIT   = 2;
	localparam int ACC_IRQ_GLB_BIT  = 3;
	// ----------------------------------------
	// Reset values and codes
	// ----------------------------------------
	localparam logic [7:0] ACC_CTRL0_RST = 8'h00;
	localparam logic [7:0] ACC_CTRL1_RST = 8'h00;
	localparam logic [2:0] ACC_SRC_BANDGAP = 3'h1;
	localparam logic [2:0] ACC_SRC_AMP0    = 3'h2;
	localparam logic [2:0] ACC_SRC_AMP1    = 3'h3;
	localparam logic [2:0] ACC_SRC_VSS     = 3'h4;
	localparam logic [3:0] ACC_CHAN_FLOAT  = 4'hE;
	// ----------------------------------------
	// Conversion timing in conversion clock cycles
	// ----------------------------------------
	localparam int ACC_SAMPLE_CYC  = 4;
	localparam int ACC_CONVERT_CYC = 12;
	localparam int ACC_TOTAL_CYC   = ACC_SAMPLE_CYC + ACC_CONVERT_CYC;
	localparam int ACC_RES_W       = 12;
	typedef enum logic [1:0] {
		ACC_ST_IDLE   = 2'b00,
		ACC_ST_RESET  = 2'b01,
		ACC_ST_SAMPLE = 2'b10,
		ACC_ST_CONV   = 2'b11
	} acc_state_t;
endpackage

// File: sim/acc_sar_model.sv
`timescale 1ns/10ps
module acc_sar_model (
	input  wire logic        i_clk,
	input  wire logic        i_power_on,
	input  wire logic        i_ext_connect,
	input  wire logic [3:0]  i_ext_channel,
	input  wire logic [2:0]  i_int_source,
	output logic      [11:0] o_code
);
	initial o_code = 12'h5A5;
	// Unpowered core gives no stable code, so flip it every cycle
	always @(posedge i_clk) begin
		if (!i_power_on)
			o_code <= ~o_code;
		else if (i_ext_connect)
			o_code <= {4'hA, i_ext_channel, 4'h5};
		else
			o_code <= {4'h3, 1'b0, i_int_source, 4'hC};
	end
endmodule

// File: sim/tb.sv
`timescale 1ns/10ps
module tb;
	import acc_pkg::*;
	logic        i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
	logic [2:0]  i_addr = 3'h0;
	logic [7:0]  i_wdata = 8'h00;
	logic [7:0]  o_rdata;
	logic [11:0] code;
	logic        o_power_on, o_conv_reset, o_sample, o_convert;
	logic        o_ext_connect, o_irq;
	logic [3:0]  o_ext_channel;
	logic [2:0]  o_int_source;
	logic [1:0]  o_vref_sel;
	int          failures = 0, checks = 0;
	acc_conv_ctrl DUT (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_sar_code(code), .o_power_on(o_power_on),
		.o_conv_reset(o_conv_reset), .o_sample(o_sample),
		.o_convert(o_convert), .o_ext_connect(o_ext_connect),
		.o_ext_channel(o_ext_channel), .o_int_source(o_int_source),
		.o_vref_sel(o_vref_sel), .o_irq(o_irq));
	acc_sar_model core (.i_clk(i_clk), .i_power_on(o_power_on),
		.i_ext_connect(o_ext_connect), .i_ext_channel(o_ext_channel),
		.i_int_source(o_int_source), .o_code(code));
	initial begin
		forever #12.5 i_clk = ~i_clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp);
	endtask
	task automatic t_conv(input logic [2:0] dv, input logic f,
		input logic [3:0] ch);
		logic [11:0] c;
		int n;
		c = {4'hA, ch, 4'h5};
		n = 0;
		wr(ACC_OFS_CTRL1, {3'h0, 2'h1, dv});
		wr(ACC_OFS_CTRL0, {3'h5, f, ch});
		chk(o_conv_reset, 1'b1);
		wr(ACC_OFS_CTRL0, {3'h1, f, ch});
		chk(o_sample, 1'b1);
		while ((o_sample | o_convert) && n < 5000) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		// Tick phase against the clock allows a small window
		chk(n >= (16 << dv) - 1 && n <= (16 << dv) + 2, 1'b1);
		rd(ACC_OFS_CTRL0, {3'h1, f, ch});
		rd(ACC_OFS_RES_HIGH, f ? {4'h0, c[11:8]} : c[11:4]);
		rd(ACC_OFS_RES_LOW, f ? c[7:0] : {c[3:0], 4'h0});
		rd(ACC_OFS_IRQ, 8'h01);
	endtask
	task automatic t_regs;
		rd(ACC_OFS_CTRL0, ACC_CTRL0_RST);
		rd(ACC_OFS_CTRL1, ACC_CTRL1_RST);
		rd(3'h6, 8'h00);
		wr(3'h7, 8'hFF);
		wr(ACC_OFS_CTRL0, 8'h83);
		chk(o_conv_reset, 1'b0);
		wr(ACC_OFS_CTRL0, 8'h03);
		chk(o_power_on, 1'b0);
		chk(o_sample | o_convert, 1'b0);
		rd(ACC_OFS_CTRL0, 8'h03);
	endtask
	task automatic t_route;
		wr(ACC_OFS_CTRL0, 8'h25);
		wr(ACC_OFS_CTRL1, ACC_SRC_BANDGAP << ACC_C1_SRC_LSB);
		chk(o_ext_connect, 1'b0);
		chk(o_int_source, ACC_SRC_BANDGAP);
		wr(ACC_OFS_CTRL1, 8'hF8);
		chk(o_ext_connect, 1'b1);
		chk(o_ext_channel, 4'h5);
		chk(o_vref_sel, 2'h3);
		wr(ACC_OFS_CTRL0, {4'h2, ACC_CHAN_FLOAT});
		chk(o_ext_connect, 1'b0);
	endtask
	task automatic t_irq;
		wr(ACC_OFS_IRQ, 8'h07);
		chk(o_irq, 1'b0);
		wr(ACC_OFS_IRQ, 8'h0F);
		chk(o_irq, 1'b1);
		wr(ACC_OFS_IRQ, 8'h0E);
		chk(o_irq, 1'b0);
		rd(ACC_OFS_IRQ, 8'h0E);
		wr(ACC_OFS_CTRL0, 8'h00);
		chk(o_power_on, 1'b0);
		chk(o_ext_connect, 1'b0);
	endtask
	task automatic results;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge i_clk);
		i_rst <= 1'b0;
		t_regs();
		t_route();
		t_conv(3'h0, 1'b0, 4'h3);
		t_conv(3'h1, 1'b1, 4'h5);
		t_conv(3'h7, 1'b0, 4'hD);
		t_irq();
		results();
	end
	initial begin
		#(25 * 20000);
		failures++;
		results();
	end
endmodule
